// ### bench/irqc_cpu_model.sv
/*
  Processor side: samples the priority level once a cycle as a core would.
  Assumes the level is a registered output on mclk.
*/
`timescale 1ns/1ps
module irqc_cpu_model
  import irqc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic [2:0] irq_level,
  output logic      [2:0] ipl_seen
);
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      ipl_seen <= LEVEL_NONE;
    else
      ipl_seen <= irq_level;
  end
endmodule : irqc_cpu_model

// ### bench/irqc_top_assertions.sv
/*
  Port checker for irqc_top: bus answers, read data shape and level gating.
  Assumes one AXI4-Lite master that offers write address and data together.
*/
`timescale 1ns/1ps
module irqc_top_assertions
  import irqc_pkg::*;
(
  input wire logic                          mclk,
  input wire logic                          rstn,
  input wire logic [irqc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic                          s_axi_awvalid,
  input wire logic                          s_axi_awready,
  input wire logic [31:0]                   s_axi_wdata,
  input wire logic [3:0]                    s_axi_wstrb,
  input wire logic                          s_axi_wvalid,
  input wire logic                          s_axi_wready,
  input wire logic [1:0]                    s_axi_bresp,
  input wire logic                          s_axi_bvalid,
  input wire logic                          s_axi_bready,
  input wire logic [irqc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic                          s_axi_arvalid,
  input wire logic                          s_axi_arready,
  input wire logic [31:0]                   s_axi_rdata,
  input wire logic [1:0]                    s_axi_rresp,
  input wire logic                          s_axi_rvalid,
  input wire logic [2:0]                    irq_level
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Shadow of the master gate, so gating is checked without seeing the registers.
  logic gate_q;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      gate_q <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
             s_axi_awaddr == OFF_ENABLE_SETCLR && s_axi_wdata[14] && &s_axi_wstrb[1:0])
      gate_q <= s_axi_wdata[15];
  end

  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence gate_off_held;
    !gate_q [*3];
  endsequence

  never_seven_a: assert property (irq_level != 3'h7)
    else $error("level seven driven");
  gate_block_a: assert property (gate_off_held |-> irq_level == LEVEL_NONE)
    else $error("level raised with master gate off");
  write_resp_a: assert property (both_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  ro_write_a: assert property ((both_taken ##0 s_axi_awaddr[2]) |->
    ##[1:2] (s_axi_bvalid && s_axi_bresp == RESP_SLVERR)) else $error("read port written");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  wo_read_a: assert property (s_axi_arvalid && s_axi_arready && !s_axi_araddr[2] |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("write port read");
  rd_ok_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == OFF_REQUEST_READ |=> s_axi_rresp == RESP_OKAY) else $error("bad rresp");
  read_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h0)
    else $error("upper read bits set");
endmodule : irqc_top_assertions

bind irqc_top irqc_top_assertions u_chk (.mclk(mclk), .rstn(rstn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .irq_level(irq_level));

// ### bench/testbench.sv
/*
  Self-checking bench for irqc_top: AXI4-Lite master, event strobes and pins.
  Assumes the cpu model shows the level one cycle after the design drives it.
*/
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module testbench;
  import irqc_pkg::*;
  logic          mclk = 0, rstn = 0;
  logic [3:0]    awa = 0, ara = 0, ws = 4'hF;
  logic [31:0]   wd = 0, rdata;
  logic          awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0, hi_n = 1, lo_n = 1;
  logic          awr, wrd, bv, arr, rv;
  logic [1:0]    bresp, rresp;
  logic [2:0]    lvl, seen;
  irqc_events_t  ev = '0;
  logic [31:0]   seed = 32'h6A20;
  int            err_total = 0, n_checks = 0, stall = 0;

  irqc_top u_dut (.mclk(mclk), .rstn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brd),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrd), .events(ev),
    .high_external_irq_n(hi_n), .low_external_irq_n(lo_n), .irq_level(lvl));
  irqc_cpu_model u_cpu (.mclk(mclk), .rstn(rstn), .irq_level(lvl), .ipl_seen(seen));

  initial forever #50 mclk = ~mclk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [2:0] exp_lvl(input logic [14:0] e, input logic [14:0] q);
    logic [14:0] a;
    a = e & q & {1'b0, {14{e[14]}}};
    if (a[13]) return LEVEL_6;
    if (|a[12:11]) return LEVEL_5;
    if (|a[10:7]) return LEVEL_4;
    if (|a[6:4]) return LEVEL_3;
    if (a[3]) return LEVEL_2;
    if (|a[2:0]) return LEVEL_1;
    return LEVEL_NONE;
  endfunction : exp_lvl

  ////////////////////////////////////////////////////////////////////////////////
  // A late bready exercises the slave's duty to hold its response.
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    @(posedge mclk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
    forever begin
      @(posedge mclk);
      t++;
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv && brd) break;
      brd <= (t > stall);
    end
    r = bresp;
    brd <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    ara <= a; arv <= 1'b1; rrd <= 1'b1;
    do begin @(posedge mclk); if (arr) arv <= 1'b0; end while (rv !== 1'b1);
    d = rdata; r = rresp;
    rrd <= 1'b0;
  endtask : rd

  task automatic wok(input logic [3:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    `CHK("bresp", RESP_OKAY, r)
  endtask : wok

  task automatic chk_rd(input logic [3:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `CHK(n, e, d)
    `CHK("rresp", RESP_OKAY, r)
  endtask : chk_rd

  task automatic apply(input logic [14:0] e, input logic [14:0] q);
    wok(OFF_ENABLE_SETCLR, 32'h7FFF);
    wok(OFF_ENABLE_SETCLR, {16'h0, 1'b1, e});
    wok(OFF_REQUEST_SETCLR, 32'h7FFF);
    wok(OFF_REQUEST_SETCLR, {16'h0, 1'b1, q});
    repeat (4) @(posedge mclk);
    `CHK("level", exp_lvl(e, q), seen)
    chk_rd(OFF_ENABLE_READ, {17'h0, e}, "enable");
    chk_rd(OFF_REQUEST_READ, {17'h0, q}, "request");
  endtask : apply

  task automatic summarize();
    if (err_total == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    chk_rd(OFF_ENABLE_READ, 32'h0, "enable reset");
    chk_rd(OFF_REQUEST_READ, 32'h0, "request reset");
    for (int i = 0; i < 14; i++)
      apply(15'h4000 | (15'h1 << i), 15'h1 << i);
    apply(15'h3FFF, 15'h3FFF);
    apply(15'h4000, 15'h4000);
    apply(15'h5FFF, 15'h2000);
    for (int i = 0; i < 8; i++) begin
      stall = int'(rnd() % 3);
      apply(15'(rnd()), 15'(rnd()));
    end
    apply(15'h7FFF, 15'h0003);
    wok(OFF_REQUEST_SETCLR, 32'h8000);
    wok(OFF_REQUEST_SETCLR, 32'h0001);
    chk_rd(OFF_REQUEST_READ, 32'h0002, "one cleared");
    wok(OFF_ENABLE_SETCLR, 32'h0001);
    ws <= 4'hC;
    wok(OFF_ENABLE_SETCLR, 32'h8001);
    ws <= 4'hF;
    chk_rd(OFF_ENABLE_READ, 32'h7FFE, "partial strobe");
    wr(OFF_REQUEST_READ, 32'hFFFF, r);
    `CHK("ro bresp", RESP_SLVERR, r)
    rd(OFF_ENABLE_SETCLR, d, r);
    `CHK("wo rresp", RESP_SLVERR, r)
    `CHK("wo rdata", 32'h0, d)
    rd(4'h2, d, r);
    `CHK("gap rresp", RESP_SLVERR, r)
    chk_rd(OFF_REQUEST_READ, 32'h0002, "request kept");
    for (int i = 0; i < 10; i++) begin
      wok(OFF_REQUEST_SETCLR, 32'h7FFF);
      ev <= irqc_events_t'(10'h1 << i);
      @(posedge mclk);
      ev <= '0;
      chk_rd(OFF_REQUEST_READ, 32'h1 << (i < 2 ? i : i + 3), "event");
      chk_rd(OFF_REQUEST_READ, 32'h1 << (i < 2 ? i : i + 3), "sticky");
    end
    for (int p = 0; p < 2; p++) begin
      wok(OFF_REQUEST_SETCLR, 32'h7FFF);
      if (p == 1) hi_n <= 1'b0;
      else lo_n <= 1'b0;
      repeat (8) @(posedge mclk);
      hi_n <= 1'b1;
      lo_n <= 1'b1;
      repeat (8) @(posedge mclk);
      chk_rd(OFF_REQUEST_READ, p == 1 ? 32'h2000 : 32'h0008, "pin");
      wok(OFF_REQUEST_SETCLR, 32'h7FFF);
      chk_rd(OFF_REQUEST_READ, 32'h0, "pin cleared");
    end
    summarize();
  end

  initial begin
    repeat (30000) @(posedge mclk);
    err_total++;
    summarize();
  end
endmodule : testbench

// ### hdl/irqc_level_encoder.sv
/*
  Priority encoder from the qualified request vector to a processor level.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps
module irqc_level_encoder
  import irqc_pkg::*;
(
  input  wire logic [14:0] active,
  output logic      [2:0]  level
);

  // Highest level is tested first so it always wins. Bit 14 is never looked at.
  always_comb
  begin
    level = LEVEL_NONE;
    if (active[POS_HIGH_EXT])
      level = LEVEL_6;
    else if (active[POS_DISK_SYNC] || active[POS_SERIAL_RX])
      level = LEVEL_5;
    else if (|active[POS_AUDIO_LO +: NUM_AUDIO])
      level = LEVEL_4;
    else if (active[POS_BLOCK_XFER] || active[POS_VBLANK] || active[POS_COPROC])
      level = LEVEL_3;
    else if (active[POS_LOW_EXT])
      level = LEVEL_2;
    else if (active[POS_DISK_DONE] || active[POS_SERIAL_TX] || active[POS_SOFT_ONLY])
      level = LEVEL_1;
  end

endmodule : irqc_level_encoder

// ### hdl/irqc_pkg.sv
/*
  Package for the interrupt request controller: register offsets, field positions,
  reset values, level codes and the packed carriers shared by the two design files.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package irqc_pkg;

  localparam int unsigned AXI_ADDR_W = 4;

  // Register byte offsets.
  localparam logic [3:0] OFF_ENABLE_SETCLR  = 4'h0;
  localparam logic [3:0] OFF_ENABLE_READ    = 4'h4;
  localparam logic [3:0] OFF_REQUEST_SETCLR = 4'h8;
  localparam logic [3:0] OFF_REQUEST_READ   = 4'hC;

  // Field positions inside the 16-bit interrupt registers.
  localparam int unsigned POS_WRITE_POLARITY = 15;
  localparam int unsigned POS_MASTER_GATE    = 14;
  localparam int unsigned POS_HIGH_EXT       = 13;
  localparam int unsigned POS_DISK_SYNC      = 12;
  localparam int unsigned POS_SERIAL_RX      = 11;
  localparam int unsigned POS_AUDIO_LO       = 7;
  localparam int unsigned POS_BLOCK_XFER     = 6;
  localparam int unsigned POS_VBLANK         = 5;
  localparam int unsigned POS_COPROC         = 4;
  localparam int unsigned POS_LOW_EXT        = 3;
  localparam int unsigned POS_SOFT_ONLY      = 2;
  localparam int unsigned POS_DISK_DONE      = 1;
  localparam int unsigned POS_SERIAL_TX      = 0;

  localparam int unsigned NUM_AUDIO = 4;

  // Reset values of the stored registers.
  localparam logic [14:0] RESET_ENABLE  = 15'h0000;
  localparam logic [14:0] RESET_REQUEST = 15'h0000;

  // Processor priority level codes.
  localparam logic [2:0] LEVEL_NONE = 3'h0;
  localparam logic [2:0] LEVEL_1    = 3'h1;
  localparam logic [2:0] LEVEL_2    = 3'h2;
  localparam logic [2:0] LEVEL_3    = 3'h3;
  localparam logic [2:0] LEVEL_4    = 3'h4;
  localparam logic [2:0] LEVEL_5    = 3'h5;
  localparam logic [2:0] LEVEL_6    = 3'h6;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Hardware event strobes, one cycle each, from logic on mclk.
  typedef struct packed {
    logic                 disk_sync_match;
    logic                 serial_rx_full;
    logic [NUM_AUDIO-1:0] audio_done;
    logic                 block_transfer_done;
    logic                 vertical_blank_event;
    logic                 disk_transfer_done;
    logic                 serial_tx_empty;
  } irqc_events_t;

endpackage : irqc_pkg

// ### hdl/irqc_top.sv
/*
  Interrupt request controller: enable mask and request status registers with
  set/clear writes, hardware event capture and processor level output.
  Assumes event strobes come from logic on mclk and the two external lines are
  asynchronous pins. Software reaches the registers over AXI4-Lite.
*/
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

// Summary of operation
// - Enable and request, separate write/read addresses.
// - Bit15 one: set selected bits.
// - Bit15 zero: clear selected bits.
// - Zero selector bits leave register unchanged.
// - Read addresses report no bit 15.
// - Request and enable bits share positions.
// - Bit 14 master gate blocks everything.
// - Master position never requests by itself.
// - High external line low sets bit 13, level 6.
// - Low external line low sets bit 3, level 2.
// - Vertical blank line zero sets bit 5.
// - Bit 4 coprocessor, software written, level 3.
// - Bits 10-7 audio channels 3-0, level 4.
// - Audio done strobes from audio logic.
// - Block transfer done sets bit 6, level 3.
// - Disk sync match sets bit 12, level 5.
// - Disk block done sets bit 1, level 1.
// - Level 7 is never generated.
// - Disabled pending request causes no interrupt.
// - Output covers levels 1 through 6.
// - Serial receive full sets bit 11, level 5.
// - Serial transmit empty sets bit 0, level 1.
module irqc_top
  import irqc_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  input  wire logic [irqc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [irqc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire irqc_pkg::irqc_events_t    events,
  input  wire logic                      high_external_irq_n,
  input  wire logic                      low_external_irq_n,
  output logic [2:0]                     irq_level
);

  import irqc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Write channel capture.

  logic [AXI_ADDR_W-1:0] wr_addr;
  logic                  wr_addr_held;
  logic [31:0]           wr_data;
  logic [3:0]            wr_strb;
  logic                  wr_data_held;
  logic                  wr_fire;

  // Address and data are accepted independently; the write fires once both are held
  // and no response is still outstanding.
  // A second write may be taken while a response waits, but it stays in the holding
  // registers until the master has taken that response.
  assign wr_fire = wr_addr_held && wr_data_held && !s_axi_bvalid;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_awready <= 1'b0;
      wr_addr_held  <= 1'b0;
      wr_addr       <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      s_axi_awready <= 1'b0;
      wr_addr_held  <= 1'b1;
      wr_addr       <= s_axi_awaddr;
    end
    else if (wr_fire)
    begin
      wr_addr_held  <= 1'b0;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !wr_addr_held;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_wready <= 1'b0;
      wr_data_held <= 1'b0;
      wr_data      <= '0;
      wr_strb      <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      s_axi_wready <= 1'b0;
      wr_data_held <= 1'b1;
      wr_data      <= s_axi_wdata;
      wr_strb      <= s_axi_wstrb;
    end
    else if (wr_fire)
    begin
      wr_data_held <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_wready <= !wr_data_held;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write decode. Both 16-bit registers live in the low two byte lanes, so a
  // write that misses either lane is ignored rather than half applied.

  logic wr_lanes_ok;
  logic wr_enable_hit;
  logic wr_request_hit;
  logic wr_mapped;

  assign wr_lanes_ok    = wr_strb[0] && wr_strb[1];
  assign wr_enable_hit  = wr_fire && wr_lanes_ok && (wr_addr == OFF_ENABLE_SETCLR);
  assign wr_request_hit = wr_fire && wr_lanes_ok && (wr_addr == OFF_REQUEST_SETCLR);
  assign wr_mapped      = (wr_addr == OFF_ENABLE_SETCLR) || (wr_addr == OFF_REQUEST_SETCLR);

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      // A write to a read address or a hole changes nothing and is answered with an
      // error, so a stray pointer cannot disturb the mask.
      s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // External line synchronisers. Stage one feeds only stage two; a level change
  // counts once stages two and three agree.

  localparam int unsigned NUM_EXT = 2;

  logic [NUM_EXT-1:0] ext_pin_n;
  logic               high_ext_low;
  logic               low_ext_low;

  assign ext_pin_n = {high_external_irq_n, low_external_irq_n};

  // Reset fills each chain with the idle high level, so the release of reset
  // never looks like a pin going low.
  for (genvar g = 0; g < NUM_EXT; g++)
  begin : g_ext_sync
    logic [2:0] sync;
    logic       low_seen;

    always_ff @(posedge mclk or negedge rstn)
    begin
      if (!rstn)
      begin
        sync     <= 3'h7;
        low_seen <= 1'b0;
      end
      else
      begin
        sync <= {sync[1:0], ext_pin_n[g]};
        if (sync[1] == sync[2])
          low_seen <= !sync[2];
      end
    end
  end

  assign high_ext_low = g_ext_sync[1].low_seen;
  assign low_ext_low  = g_ext_sync[0].low_seen;

  //////////////////////////////////////////////////////////////////////////////
  // Hardware set vector, one bit per request position.

  logic [14:0] hw_set;

  always_comb
  begin
    hw_set                                 = '0;
    hw_set[POS_HIGH_EXT]                   = high_ext_low;
    hw_set[POS_LOW_EXT]                    = low_ext_low;
    hw_set[POS_VBLANK]                     = events.vertical_blank_event;
    hw_set[POS_AUDIO_LO +: NUM_AUDIO]      = events.audio_done;
    hw_set[POS_BLOCK_XFER]                 = events.block_transfer_done;
    hw_set[POS_DISK_SYNC]                  = events.disk_sync_match;
    hw_set[POS_DISK_DONE]                  = events.disk_transfer_done;
    hw_set[POS_SERIAL_RX]                  = events.serial_rx_full;
    hw_set[POS_SERIAL_TX]                  = events.serial_tx_empty;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Stored registers. Bit 15 of a write is the polarity, bits 14-0 select.

  logic [14:0] enable_mask;
  logic [14:0] request;
  logic [14:0] wr_select;
  logic        wr_polarity;

  assign wr_select   = wr_data[14:0];
  assign wr_polarity = wr_data[POS_WRITE_POLARITY];

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      enable_mask <= RESET_ENABLE;
    else if (wr_enable_hit)
    begin
      if (wr_polarity)
        enable_mask <= enable_mask | wr_select;
      else
        enable_mask <= enable_mask & ~wr_select;
    end
  end

  // A hardware event in the same cycle as a software clear wins, so it is not lost.
  // Bit 4 has no hardware source; only software writes reach it.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      request <= RESET_REQUEST;
    else if (wr_request_hit && wr_polarity)
      request <= request | wr_select | hw_set;
    else if (wr_request_hit)
      request <= (request & ~wr_select) | hw_set;
    else
      request <= request | hw_set;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Level output. Position 14 is masked off before encoding.

  logic [14:0] qualified;
  logic [2:0]  next_irq_level;

  always_comb
  begin
    qualified                  = request & enable_mask;
    qualified[POS_MASTER_GATE] = 1'b0;
    if (!enable_mask[POS_MASTER_GATE])
      qualified = '0;
  end

  irqc_level_encoder u_encoder
  (
    .active (qualified),
    .level  (next_irq_level)
  );

  // The encoder tops out at six, so level 7 stays free for outside hardware.
  // The level is registered, so it follows a changed register or an event one
  // cycle after the stored bit has changed.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      irq_level <= LEVEL_NONE;
    else
      irq_level <= next_irq_level;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read channel. Write-only addresses read as zero with an error response.
  // Read data are captured at the edge that accepts the address, so a write that
  // completes at that same edge is not yet seen.

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      unique case (s_axi_araddr)
        OFF_ENABLE_READ:
        begin
          s_axi_rdata <= {17'h00000, enable_mask};
          s_axi_rresp <= RESP_OKAY;
        end
        OFF_REQUEST_READ:
        begin
          s_axi_rdata <= {17'h00000, request};
          s_axi_rresp <= RESP_OKAY;
        end
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else
    begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule : irqc_top
